// ---- logic/pcr_config_upper.sv ----
// Summary of operation
// - control space base bits 31..15 are host writable to place the 32 KB region
// - control space base bits 14..4 ignore writes and read zero
// - prefetchable bit 3 of both base registers reads zero
// - type field bits 2..1 of both base registers reads 00
// - space indicator bit 0 of both base registers reads zero
// - auxiliary window low eight bits read zero and are not writable
// - with auxiliary bus disabled, its base ignores writes and reads zero
// - with auxiliary bus enabled, base bits 31..8 are host writable
// - auxiliary base bits 7..4 ignore writes and read zero
// - subsystem vendor and product codes writable only while write lock is 0
// - subsystem codes load from serial memory, else reset to zero
// - capability pointer reads fixed 50h
// - interrupt routing byte is read/write, resets to FFh
// - interrupt pin reads fixed 01h, meaning INTA
// - minimum burst period is read-only 00h
`timescale 1ns/10ps
module pcr_config_upper (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  // configuration access from the host interface
  input pcr_pkg::pcr_cfg_req_type CFG_REQ_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_ACK_O,
  // controls from the miscellaneous control register
  input wire logic AUX_BUS_ENABLE_I,
  input wire logic SUBSYSTEM_WRITE_LOCK_I,
  // serial configuration memory load
  input pcr_pkg::pcr_rom_load_type ROM_LOAD_I,
  // memory transaction decode
  input pcr_pkg::pcr_mem_req_type MEM_REQ_I,
  output logic CTRL_SPACE_HIT_O,
  output logic AUX_WINDOW_HIT_O,
  // interrupt routing byte for system use
  output logic [7:0] INTERRUPT_ROUTING_LINE_O
);
  import pcr_pkg::*;

  localparam logic [PCR_IDX_W-1:0] IDX_CTRL = PCR_OFF_CTRL_BASE[7:2];
  localparam logic [PCR_IDX_W-1:0] IDX_AUX = PCR_OFF_AUX_BASE[7:2];
  localparam logic [PCR_IDX_W-1:0] IDX_SUBSYS = PCR_OFF_SUBSYS_VENDOR[7:2];
  localparam logic [PCR_IDX_W-1:0] IDX_CAP = PCR_OFF_CAP_PTR[7:2];
  localparam logic [PCR_IDX_W-1:0] IDX_INT = PCR_OFF_INT_LINE[7:2];
  localparam int LANE_VENDOR = PCR_OFF_SUBSYS_VENDOR[1:0];
  localparam int LANE_PRODUCT = PCR_OFF_SUBSYS_PRODUCT[1:0];
  localparam int LANE_CAP = PCR_OFF_CAP_PTR[1:0];
  localparam int LANE_LINE = PCR_OFF_INT_LINE[1:0];
  localparam int LANE_PIN = PCR_OFF_INT_PIN[1:0];
  localparam int LANE_MINB = PCR_OFF_MIN_BURST[1:0];

  logic [31:0] ctrl_base;
  logic [31:0] aux_base;
  logic ctrl_wr;
  logic aux_wr;
  logic subsys_wr;
  logic [15:0] vendor_reg;
  logic [15:0] vendor_next;
  logic [15:0] product_reg;
  logic [15:0] product_next;
  logic [7:0] line_reg;
  logic [7:0] line_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic ctrl_hit_reg;
  logic ctrl_hit_next;
  logic aux_hit_reg;
  logic aux_hit_next;

  // write strobes per register
  assign ctrl_wr = CFG_REQ_I.wr && (CFG_REQ_I.index == IDX_CTRL);
  assign aux_wr = CFG_REQ_I.wr && (CFG_REQ_I.index == IDX_AUX) && AUX_BUS_ENABLE_I;
  assign subsys_wr = CFG_REQ_I.wr && (CFG_REQ_I.index == IDX_SUBSYS) && !SUBSYSTEM_WRITE_LOCK_I;

  // control space base: only bits 31..15 stored, low field reads zero
  pcr_base_reg #(
    .WRITE_MASK(PCR_CTRL_WRITABLE_MASK),
    .RESET_VALUE(PCR_BASE_RESET)
  ) u_ctrl_base (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .clear_i(1'b0),
    .wr_i(ctrl_wr),
    .be_i(CFG_REQ_I.be),
    .wdata_i(CFG_REQ_I.wdata),
    .value_o(ctrl_base)
  );

  // auxiliary window base: cleared while the auxiliary bus is off
  pcr_base_reg #(
    .WRITE_MASK(PCR_AUX_WRITABLE_MASK),
    .RESET_VALUE(PCR_BASE_RESET)
  ) u_aux_base (
    .clk_i(CLK_I),
    .rst_i(RESET_I),
    .clear_i(!AUX_BUS_ENABLE_I),
    .wr_i(aux_wr),
    .be_i(CFG_REQ_I.be),
    .wdata_i(CFG_REQ_I.wdata),
    .value_o(aux_base)
  );

  // subsystem codes and interrupt routing byte; loader wins over a host write
  always_comb begin
    vendor_next = vendor_reg;
    product_next = product_reg;
    line_next = line_reg;
    if (ROM_LOAD_I.valid) begin
      vendor_next = ROM_LOAD_I.vendor;
      product_next = ROM_LOAD_I.product;
    end else if (subsys_wr) begin
      for (int b = 0; b < 2; b++) begin
        if (CFG_REQ_I.be[LANE_VENDOR + b]) begin
          vendor_next[8*b +: 8] = CFG_REQ_I.wdata[8*(LANE_VENDOR + b) +: 8];
        end
        if (CFG_REQ_I.be[LANE_PRODUCT + b]) begin
          product_next[8*b +: 8] = CFG_REQ_I.wdata[8*(LANE_PRODUCT + b) +: 8];
        end
      end
    end
    if (CFG_REQ_I.wr && (CFG_REQ_I.index == IDX_INT) && CFG_REQ_I.be[LANE_LINE]) begin
      line_next = CFG_REQ_I.wdata[8*LANE_LINE +: 8];
    end
  end

  // subsystem and routing storage
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      vendor_reg <= PCR_SUBSYS_RESET;
      product_reg <= PCR_SUBSYS_RESET;
      line_reg <= PCR_INT_LINE_RESET;
    end else begin
      vendor_reg <= vendor_next;
      product_reg <= product_next;
      line_reg <= line_next;
    end
  end

  // read mux and acknowledge for dwords owned by this block
  always_comb begin
    rdata_next = PCR_ZERO_WORD;
    ack_next = 1'b0;
    if (CFG_REQ_I.rd || CFG_REQ_I.wr) begin
      case (CFG_REQ_I.index)
        IDX_CTRL: begin
          ack_next = 1'b1;
          rdata_next = ctrl_base;
        end
        IDX_AUX: begin
          ack_next = 1'b1;
          rdata_next = AUX_BUS_ENABLE_I ? aux_base : PCR_ZERO_WORD;
        end
        IDX_SUBSYS: begin
          ack_next = 1'b1;
          rdata_next[8*LANE_VENDOR +: 16] = vendor_reg;
          rdata_next[8*LANE_PRODUCT +: 16] = product_reg;
        end
        IDX_CAP: begin
          ack_next = 1'b1;
          rdata_next[8*LANE_CAP +: 8] = PCR_CAP_PTR_VALUE;
        end
        IDX_INT: begin
          ack_next = 1'b1;
          rdata_next[8*LANE_LINE +: 8] = line_reg;
          rdata_next[8*LANE_PIN +: 8] = PCR_INT_PIN_VALUE;
          rdata_next[8*LANE_MINB +: 8] = PCR_MIN_BURST_VALUE;
        end
        default: begin
          ack_next = 1'b0;
        end
      endcase
      if (!CFG_REQ_I.rd) begin
        rdata_next = PCR_ZERO_WORD;
      end
    end
  end

  // memory decode against the writable base bits
  always_comb begin
    ctrl_hit_next = MEM_REQ_I.valid &&
      ((MEM_REQ_I.addr & PCR_CTRL_WRITABLE_MASK) == ctrl_base);
    aux_hit_next = MEM_REQ_I.valid && AUX_BUS_ENABLE_I &&
      ((MEM_REQ_I.addr & PCR_AUX_WRITABLE_MASK) == aux_base);
  end

  // answer and decode registers
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rdata_reg <= PCR_ZERO_WORD;
      ack_reg <= 1'b0;
      ctrl_hit_reg <= 1'b0;
      aux_hit_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      ctrl_hit_reg <= ctrl_hit_next;
      aux_hit_reg <= aux_hit_next;
    end
  end

  // outputs come straight from registers
  assign CFG_RDATA_O = rdata_reg;
  assign CFG_ACK_O = ack_reg;
  assign CTRL_SPACE_HIT_O = ctrl_hit_reg;
  assign AUX_WINDOW_HIT_O = aux_hit_reg;
  assign INTERRUPT_ROUTING_LINE_O = line_reg;

  // checks on the register behaviour
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RESET_I);

  property p_ctrl_write;
    CFG_REQ_I.wr && CFG_REQ_I.index == IDX_CTRL && CFG_REQ_I.be == 4'hf
      |=> ctrl_base == ($past(CFG_REQ_I.wdata) & 32'hffff8000);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control base write not stored");

  property p_ctrl_low_zero;
    CFG_REQ_I.rd && CFG_REQ_I.index == IDX_CTRL |=> CFG_ACK_O && CFG_RDATA_O[14:0] == 15'h0000;
  endproperty
  a_ctrl_low_zero: assert property (p_ctrl_low_zero) else $error("control base low bits not zero");

  property p_aux_flags_zero;
    CFG_REQ_I.rd && CFG_REQ_I.index == IDX_AUX |=> CFG_RDATA_O[7:0] == 8'h00;
  endproperty
  a_aux_flags_zero: assert property (p_aux_flags_zero) else $error("aux base low byte not zero");

  property p_aux_disabled;
    !AUX_BUS_ENABLE_I ##1 (CFG_REQ_I.rd && CFG_REQ_I.index == IDX_AUX && !AUX_BUS_ENABLE_I)
      |=> CFG_RDATA_O == 32'h00000000 && aux_base == 32'h00000000;
  endproperty
  a_aux_disabled: assert property (p_aux_disabled) else $error("aux base visible while disabled");

  property p_aux_write;
    CFG_REQ_I.wr && CFG_REQ_I.index == IDX_AUX && CFG_REQ_I.be == 4'hf && AUX_BUS_ENABLE_I
      |=> aux_base == ($past(CFG_REQ_I.wdata) & 32'hffffff00);
  endproperty
  a_aux_write: assert property (p_aux_write) else $error("aux base write not stored");

  property p_subsys_lock;
    SUBSYSTEM_WRITE_LOCK_I && !ROM_LOAD_I.valid |=> $stable(vendor_reg) && $stable(product_reg);
  endproperty
  a_subsys_lock: assert property (p_subsys_lock) else $error("locked subsystem code changed");

  property p_rom_load;
    ROM_LOAD_I.valid |=> vendor_reg == $past(ROM_LOAD_I.vendor) && product_reg == $past(ROM_LOAD_I.product);
  endproperty
  a_rom_load: assert property (p_rom_load) else $error("serial load not taken");

  property p_cap_ptr;
    CFG_REQ_I.rd && CFG_REQ_I.index == IDX_CAP |=> CFG_ACK_O && CFG_RDATA_O == 32'h00000050;
  endproperty
  a_cap_ptr: assert property (p_cap_ptr) else $error("capability pointer wrong");

  property p_line_reset;
    $fell(RESET_I) |-> INTERRUPT_ROUTING_LINE_O == 8'hff;
  endproperty
  a_line_reset: assert property (@(posedge CLK_I) p_line_reset) else $error("routing byte reset wrong");

  property p_int_dword;
    CFG_REQ_I.rd && CFG_REQ_I.index == IDX_INT
      |=> CFG_RDATA_O[31:8] == 24'h000001 && CFG_RDATA_O[7:0] == $past(line_reg);
  endproperty
  a_int_dword: assert property (p_int_dword) else $error("interrupt dword read wrong");

  property p_ctrl_hit;
    MEM_REQ_I.valid && (MEM_REQ_I.addr[31:15] == ctrl_base[31:15]) |=> CTRL_SPACE_HIT_O;
  endproperty
  a_ctrl_hit: assert property (p_ctrl_hit) else $error("control space hit missed");

  property p_aux_no_hit;
    !AUX_BUS_ENABLE_I |=> !AUX_WINDOW_HIT_O;
  endproperty
  a_aux_no_hit: assert property (p_aux_no_hit) else $error("aux hit while disabled");

  property p_base_reset;
    $fell(RESET_I) |-> ctrl_base == 32'h00000000 && aux_base == 32'h00000000;
  endproperty
  a_base_reset: assert property (p_base_reset) else $error("base register not cleared by reset");

  property p_subsys_write;
    CFG_REQ_I.wr && CFG_REQ_I.index == IDX_SUBSYS && CFG_REQ_I.be == 4'hf &&
      !SUBSYSTEM_WRITE_LOCK_I && !ROM_LOAD_I.valid
      |=> {product_reg, vendor_reg} == $past(CFG_REQ_I.wdata);
  endproperty
  a_subsys_write: assert property (p_subsys_write) else $error("unlocked subsystem write not stored");

  property p_line_write;
    CFG_REQ_I.wr && CFG_REQ_I.index == IDX_INT && CFG_REQ_I.be[0]
      |=> {24'h000000, INTERRUPT_ROUTING_LINE_O} == ($past(CFG_REQ_I.wdata) & 32'h000000ff);
  endproperty
  a_line_write: assert property (p_line_write) else $error("routing byte write not stored");

  property p_min_burst;
    CFG_REQ_I.rd && CFG_REQ_I.index == IDX_INT |=> CFG_ACK_O && CFG_RDATA_O[23:16] == 8'h00;
  endproperty
  a_min_burst: assert property (p_min_burst) else $error("minimum burst period not zero");

  property p_aux_hit;
    MEM_REQ_I.valid && AUX_BUS_ENABLE_I && (MEM_REQ_I.addr[31:8] == aux_base[31:8]) |=> AUX_WINDOW_HIT_O;
  endproperty
  a_aux_hit: assert property (p_aux_hit) else $error("aux window hit missed");

  property p_ctrl_no_hit;
    MEM_REQ_I.valid && (MEM_REQ_I.addr[31:15] != ctrl_base[31:15]) |=> !CTRL_SPACE_HIT_O;
  endproperty
  a_ctrl_no_hit: assert property (p_ctrl_no_hit) else $error("control space hit on foreign address");

endmodule

// ---- logic/pcr_pkg.sv ----
package pcr_pkg;

  // configuration header byte offsets handled by this block
  localparam logic [7:0] PCR_OFF_CTRL_BASE = 8'h14;
  localparam logic [7:0] PCR_OFF_AUX_BASE = 8'h18;
  localparam logic [7:0] PCR_OFF_SUBSYS_VENDOR = 8'h2c;
  localparam logic [7:0] PCR_OFF_SUBSYS_PRODUCT = 8'h2e;
  localparam logic [7:0] PCR_OFF_CAP_PTR = 8'h34;
  localparam logic [7:0] PCR_OFF_INT_LINE = 8'h3c;
  localparam logic [7:0] PCR_OFF_INT_PIN = 8'h3d;
  localparam logic [7:0] PCR_OFF_MIN_BURST = 8'h3e;

  // dword index width of a configuration access
  localparam int PCR_IDX_W = 6;

  // base register layouts: writable base bits, everything else reads zero
  localparam logic [31:0] PCR_CTRL_WRITABLE_MASK = 32'hffff8000;
  localparam logic [31:0] PCR_AUX_WRITABLE_MASK = 32'hffffff00;
  localparam logic [31:0] PCR_BASE_RESET = 32'h00000000;

  // fixed and reset values
  localparam logic [15:0] PCR_SUBSYS_RESET = 16'h0000;
  localparam logic [7:0] PCR_CAP_PTR_VALUE = 8'h50;
  localparam logic [7:0] PCR_INT_LINE_RESET = 8'hff;
  localparam logic [7:0] PCR_INT_PIN_VALUE = 8'h01;
  localparam logic [7:0] PCR_MIN_BURST_VALUE = 8'h00;
  localparam logic [31:0] PCR_ZERO_WORD = 32'h00000000;

  // one configuration access, dword addressed with byte enables
  typedef struct packed {
    logic rd;
    logic wr;
    logic [PCR_IDX_W-1:0] index;
    logic [3:0] be;
    logic [31:0] wdata;
  } pcr_cfg_req_type;

  // subsystem words delivered by the serial configuration memory loader
  typedef struct packed {
    logic valid;
    logic [15:0] vendor;
    logic [15:0] product;
  } pcr_rom_load_type;

  // memory transaction address presented for decode
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } pcr_mem_req_type;

endpackage

// ---- logic/pcr_base_reg.sv ----
`timescale 1ns/10ps
module pcr_base_reg #(
  parameter logic [31:0] WRITE_MASK = 32'hffffff00,
  parameter logic [31:0] RESET_VALUE = 32'h00000000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // write side
  input wire logic clear_i,
  input wire logic wr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  // stored base
  output logic [31:0] value_o
);
  import pcr_pkg::*;

  logic [31:0] value_reg;
  wire logic [31:0] value_next;

  // a base register with no writable bit could never be placed
  if (WRITE_MASK == 32'h00000000) begin : g_bad_mask
    $error("pcr_base_reg: WRITE_MASK has no writable bit");
  end
  if ((RESET_VALUE & ~WRITE_MASK) != 32'h00000000) begin : g_bad_reset
    $error("pcr_base_reg: RESET_VALUE sets a read-only bit");
  end

  // per byte lane: clear, masked write, or hold; read-only bits stay zero
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign value_next[8*g +: 8] = clear_i ? 8'h00 :
      (wr_i && be_i[g]) ? (wdata_i[8*g +: 8] & WRITE_MASK[8*g +: 8]) : value_reg[8*g +: 8];
  end

  // storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_reg <= RESET_VALUE;
    end else begin
      value_reg <= value_next;
    end
  end

  // stored value goes out straight from the register
  assign value_o = value_reg;

endmodule

// ---- testbench/pcr_host_model.sv ----
`timescale 1ns/10ps
module pcr_host_model (
  // clock
  input wire logic clk_i,
  // configuration request and its answer
  output pcr_pkg::pcr_cfg_req_type req_o,
  input wire logic [31:0] rdata_i,
  input wire logic ack_i
);
  import pcr_pkg::*;
  // idle bus before the first access
  initial begin
    req_o = '0;
  end
  // one access: drive for one edge, release, take the answer on the next edge
  task automatic cfg(input logic rd, input logic wr, input logic [5:0] idx, input logic [3:0] be,
    input logic [31:0] wd, output logic [31:0] data, output logic ack);
    @(posedge clk_i);
    req_o <= '{rd, wr, idx, be, wd};
    @(posedge clk_i);
    // released lines show the inverse so stale values cannot pass
    req_o <= '{1'b0, 1'b0, ~idx, ~be, ~wd};
    @(posedge clk_i);
    data = rdata_i;
    ack = ack_i;
  endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
  import pcr_pkg::*;
  logic clk;
  logic rst;
  pcr_cfg_req_type cfg_req;
  logic [31:0] cfg_rdata;
  logic cfg_ack;
  logic aux_en;
  logic lock;
  pcr_rom_load_type rom;
  pcr_mem_req_type mem;
  logic ctrl_hit;
  logic aux_hit;
  logic [7:0] route;
  int failures;
  int checked;
  logic [31:0] d;
  logic a;
  // block under test and the host driving it
  pcr_config_upper dut (
    .CLK_I(clk),
    .RESET_I(rst),
    .CFG_REQ_I(cfg_req),
    .CFG_RDATA_O(cfg_rdata),
    .CFG_ACK_O(cfg_ack),
    .AUX_BUS_ENABLE_I(aux_en),
    .SUBSYSTEM_WRITE_LOCK_I(lock),
    .ROM_LOAD_I(rom),
    .MEM_REQ_I(mem),
    .CTRL_SPACE_HIT_O(ctrl_hit),
    .AUX_WINDOW_HIT_O(aux_hit),
    .INTERRUPT_ROUTING_LINE_O(route)
  );
  pcr_host_model host (
    .clk_i(clk),
    .req_o(cfg_req),
    .rdata_i(cfg_rdata),
    .ack_i(cfg_ack)
  );
  // 8 ns clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // verdict and end of run
  task automatic summarize();
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one comparison, a mismatch printed in hex
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // owned read and write, both must be acknowledged
  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    host.cfg(1'b1, 1'b0, idx, 4'hf, 32'h0, d, a);
    chk({31'h0, a}, 32'h1);
    chk(d, exp);
  endtask
  task automatic wr(input logic [5:0] idx, input logic [3:0] be, input logic [31:0] wd);
    host.cfg(1'b0, 1'b1, idx, be, wd, d, a);
    chk({31'h0, a}, 32'h1);
    chk(d, 32'h0);
  endtask
  // memory decode request, hits judged one cycle after the take edge
  task automatic dec(input logic [31:0] adr, input logic ec, input logic ea);
    @(posedge clk);
    mem <= '{1'b1, adr};
    @(posedge clk);
    mem <= '{1'b0, ~adr};
    @(posedge clk);
    chk({30'h0, ctrl_hit, aux_hit}, {30'h0, ec, ea});
  endtask
  task automatic t_reset();
    rd(6'h05, 32'h0);
    rd(6'h06, 32'h0);
    rd(6'h0b, 32'h0);
    rd(6'h0d, 32'h00000050);
    rd(6'h0f, 32'h000001ff);
    chk({24'h0, route}, 32'hff);
    // unowned dword gets no answer
    host.cfg(1'b1, 1'b0, 6'h04, 4'hf, 32'h0, d, a);
    chk({31'h0, a}, 32'h0);
    chk(d, 32'h0);
  endtask
  task automatic t_ctrl();
    wr(6'h05, 4'hf, 32'hffffffff);
    rd(6'h05, 32'hffff8000);
    wr(6'h05, 4'hc, 32'h12340000);
    rd(6'h05, 32'h12348000);
  endtask
  task automatic t_aux();
    wr(6'h06, 4'hf, 32'hffffffff);
    rd(6'h06, 32'h0);
    @(posedge clk);
    aux_en <= 1'b1;
    wr(6'h06, 4'hf, 32'hffffffff);
    rd(6'h06, 32'hffffff00);
    wr(6'h06, 4'hf, 32'habcdef5a);
    rd(6'h06, 32'habcdef00);
    dec(32'habcdef7f, 1'b0, 1'b1);
    dec(32'habcdf000, 1'b0, 1'b0);
    dec(32'h12348abc, 1'b1, 1'b0);
    dec(32'h12340abc, 1'b0, 1'b0);
    @(posedge clk);
    aux_en <= 1'b0;
    dec(32'habcdef7f, 1'b0, 1'b0);
    rd(6'h06, 32'h0);
    @(posedge clk);
    aux_en <= 1'b1;
    rd(6'h06, 32'h0);
  endtask
  task automatic t_subsys();
    wr(6'h0b, 4'hf, 32'hbeefcafe);
    rd(6'h0b, 32'hbeefcafe);
    @(posedge clk);
    lock <= 1'b1;
    wr(6'h0b, 4'hf, 32'h12345678);
    rd(6'h0b, 32'hbeefcafe);
    @(posedge clk);
    rom <= '{1'b1, 16'h1111, 16'h2222};
    @(posedge clk);
    rom <= '{1'b0, 16'heeee, 16'hdddd};
    rd(6'h0b, 32'h22221111);
    @(posedge clk);
    lock <= 1'b0;
    wr(6'h0b, 4'h1, 32'h000000aa);
    rd(6'h0b, 32'h222211aa);
  endtask
  task automatic t_irq();
    wr(6'h0f, 4'hf, 32'haabbcc5a);
    rd(6'h0f, 32'h0000015a);
    chk({24'h0, route}, 32'h5a);
    wr(6'h0d, 4'hf, 32'hffffffff);
    rd(6'h0d, 32'h00000050);
    // second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(6'h0f, 32'h000001ff);
    rd(6'h05, 32'h0);
    rd(6'h06, 32'h0);
    rd(6'h0b, 32'h0);
  endtask
  // main sequence
  initial begin
    rst = 1'b1;
    aux_en = 1'b0;
    lock = 1'b0;
    rom = '0;
    mem = '0;
    failures = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_aux();
    t_subsys();
    t_irq();
    summarize();
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
